// ==== include/tse_pkg.sv ====
// shared constants and carrier types for the thermal sensor event/config block
package tse_pkg;

  // register index on the plain register port
  localparam logic [2:0] TSE_ADDR_CAP = 3'h0;
  localparam logic [2:0] TSE_ADDR_CFG = 3'h1;
  localparam logic [2:0] TSE_ADDR_UPPER = 3'h2;
  localparam logic [2:0] TSE_ADDR_LOWER = 3'h3;
  localparam logic [2:0] TSE_ADDR_CRIT = 3'h4;
  localparam logic [2:0] TSE_ADDR_TEMP = 3'h5;

  // capability word field positions
  localparam int TSE_CAP_BASIC = 0;
  localparam int TSE_CAP_ACCUR = 1;
  localparam int TSE_CAP_RANGE = 2;
  localparam int TSE_CAP_RES_LO = 3;
  localparam int TSE_CAP_HV = 5;
  localparam logic [1:0] TSE_CAP_RES_CODE = 2'h1;

  // configuration word field positions
  localparam int TSE_CFG_MODE = 0;
  localparam int TSE_CFG_POL = 1;
  localparam int TSE_CFG_CRIT_ONLY = 2;
  localparam int TSE_CFG_OUT_EN = 3;
  localparam int TSE_CFG_STATUS = 4;
  localparam int TSE_CFG_CLR_EVT = 5;
  localparam int TSE_CFG_ALM_LOCK = 6;
  localparam int TSE_CFG_CRIT_LOCK = 7;
  localparam int TSE_CFG_SHDN = 8;
  localparam int TSE_CFG_HYS_LO = 9;
  localparam int TSE_CFG_HYS_HI = 10;

  // reset values
  localparam logic [15:0] TSE_CFG_RESET = 16'h0000;
  localparam logic [1:0] TSE_HYS_RESET = 2'h0;

  // hysteresis codes and their size in quarter-degree steps
  localparam logic [1:0] TSE_HYS_OFF = 2'h0;
  localparam logic [1:0] TSE_HYS_1P5 = 2'h1;
  localparam logic [1:0] TSE_HYS_3P0 = 2'h2;
  localparam logic [5:0] TSE_HYS_STEPS_1P5 = 6'h06;
  localparam logic [5:0] TSE_HYS_STEPS_3P0 = 6'h0c;
  localparam logic [5:0] TSE_HYS_STEPS_6P0 = 6'h18;

  // one register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tse_bus_req_t;

  // open-drain or push-pull event pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } tse_pin_t;

endpackage

// ==== verilog/tse_event_cfg.sv ====
// thermal sensor capability, configuration and event pin logic
// Function
// - capability word 16 bits: trips supported, accuracy grade, address pin zero HV.
// - capability bits 4:3 read fixed resolution code 01, quarter degree.
// - capability bit 2 tells clamp-to-zero or signed negative readings.
// - capability bits 15:6 read zero.
// - alarm events trigger when temperature enters or leaves the alarm window.
// - critical-only bit 2 limits events to critical; frozen by alarm lock.
// - critical trip acts as comparator; clear-event cannot drop it.
// - hysteresis from bits 10:9 applies when upper or critical deasserts and when lower asserts.
// - hysteresis 00 off, 01 1.5, 10 3, 11 6 degrees; locked field.
// - interrupt mode: writing 1 to bit 5 clears event until next trigger.
// - comparator mode: reads and clear-event writes never touch the event; tracks temperature and thresholds.
// - bit 0 selects comparator (0) or interrupt (1); frozen by locks.
// - bit 1 polarity: 0 open-drain active low, 1 active high.
// - bit 3 enables event output, default off; frozen by locks.
// - status bit 4 reads 1 while an alarm or critical event is asserted.
// - alarm lock bit 6 blocks alarm trip writes, sticks until power-on reset.
// - critical lock bit 7 blocks critical trip writes, sticks until reset.
// - each lock takes effect after one single ordinary write.
// - shutdown bit 8 stops sampling, suppresses events, registers stay accessible.
// - setting shutdown ignored while locked; clearing shutdown always accepted.
// - clearing shutdown or power cycle resumes continuous sampling.
// - clear-event reads zero and does nothing in comparator mode.
// - configuration bits 15:11 read zero, writes ignored.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps

module tse_event_cfg
  import tse_pkg::*;
#(
  parameter int TEMP_W = 11,          // signed quarter-degree temperature width
  parameter bit CAP_TRIPS = 1'b1,     // alarm and critical trips present
  parameter bit CAP_HI_ACC = 1'b1,    // high accuracy grade
  parameter bit CAP_NEG = 1'b1,       // negative readings reported signed
  parameter bit CAP_HV_PIN = 1'b1     // address_pin_zero high-voltage tolerant
) (
  input wire logic i_clk,                  // 20 MHz block clock
  input wire logic i_rst_n,                // async power-on reset, active low
  input wire logic i_ce,                   // clock enable, freezes all state except the reset synchroniser when low
  input wire tse_bus_req_t i_bus,          // register port request
  output logic [15:0] o_rdata,             // read data, cycle after read strobe
  input wire logic i_smp_clk,              // sample clock from thermal_sensing_unit
  input wire logic [TEMP_W-1:0] i_temp,    // conversion result from thermal_sensing_unit
  output logic o_smp_en,                   // high while sampling is allowed
  output tse_pin_t o_evt_pin,              // event pin drive and enable
  output logic o_evt_status                // internal event condition
);

  // refuse widths at elaboration: the read path sign-extends into sixteen bits,
  // and fewer than eight bits cannot hold a useful trip range
  if (TEMP_W < 8 || TEMP_W > 15) begin : g_bad_temp_w
    $error("tse_event_cfg: TEMP_W must lie in 8..15");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration and trip storage
  logic mode_ff;
  logic pol_ff;
  logic crit_only_ff;
  logic out_en_ff;
  logic alm_lock_ff;
  logic crit_lock_ff;
  logic shdn_ff;
  logic [1:0] hys_ff;
  logic signed [TEMP_W-1:0] upper_ff;
  logic signed [TEMP_W-1:0] lower_ff;
  logic signed [TEMP_W-1:0] crit_ff;
  logic any_lock;
  logic cfg_wr;
  logic clr_evt_wr;

  assign any_lock = alm_lock_ff | crit_lock_ff;
  assign cfg_wr = i_bus.wr && (i_bus.addr == TSE_ADDR_CFG);
  // bit 5 is a write-only pulse, only meaningful in interrupt mode
  assign clr_evt_wr = cfg_wr && i_bus.wdata[TSE_CFG_CLR_EVT] && mode_ff;

  // fields frozen by either lock; old lock values decide, so one write can set a lock too
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= TSE_CFG_RESET[TSE_CFG_MODE];
      out_en_ff <= TSE_CFG_RESET[TSE_CFG_OUT_EN];
      hys_ff <= TSE_HYS_RESET;
    end else if (i_ce && cfg_wr && !any_lock) begin
      mode_ff <= i_bus.wdata[TSE_CFG_MODE];
      out_en_ff <= i_bus.wdata[TSE_CFG_OUT_EN];
      hys_ff <= i_bus.wdata[TSE_CFG_HYS_HI:TSE_CFG_HYS_LO];
    end
  end

  // polarity is never locked; critical-only is frozen by the alarm lock alone
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_ff <= TSE_CFG_RESET[TSE_CFG_POL];
      crit_only_ff <= TSE_CFG_RESET[TSE_CFG_CRIT_ONLY];
    end else if (i_ce && cfg_wr) begin
      pol_ff <= i_bus.wdata[TSE_CFG_POL];
      if (!alm_lock_ff) begin
        crit_only_ff <= i_bus.wdata[TSE_CFG_CRIT_ONLY];
      end
    end
  end

  // lock bits only ever set; a single write is enough, only power-on reset clears
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_lock_ff <= TSE_CFG_RESET[TSE_CFG_ALM_LOCK];
      crit_lock_ff <= TSE_CFG_RESET[TSE_CFG_CRIT_LOCK];
    end else if (i_ce && cfg_wr) begin
      if (i_bus.wdata[TSE_CFG_ALM_LOCK]) begin
        alm_lock_ff <= 1'b1;
      end
      if (i_bus.wdata[TSE_CFG_CRIT_LOCK]) begin
        crit_lock_ff <= 1'b1;
      end
    end
  end

  // shutdown: setting refused under a lock, clearing always taken
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      shdn_ff <= TSE_CFG_RESET[TSE_CFG_SHDN];
    end else if (i_ce && cfg_wr) begin
      if (!i_bus.wdata[TSE_CFG_SHDN]) begin
        shdn_ff <= 1'b0;
      end else if (!any_lock) begin
        shdn_ff <= 1'b1;
      end
    end
  end

  // trip registers keep the low TEMP_W bits; locks refuse the write silently
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_ff <= '0;
      lower_ff <= '0;
      crit_ff <= '0;
    end else if (i_ce && i_bus.wr) begin
      if (i_bus.addr == TSE_ADDR_UPPER && !alm_lock_ff) begin
        upper_ff <= i_bus.wdata[TEMP_W-1:0];
      end
      if (i_bus.addr == TSE_ADDR_LOWER && !alm_lock_ff) begin
        lower_ff <= i_bus.wdata[TEMP_W-1:0];
      end
      if (i_bus.addr == TSE_ADDR_CRIT && !crit_lock_ff) begin
        crit_ff <= i_bus.wdata[TEMP_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample clock and temperature code crossing
  // the code must be stable for four block clocks around the sample edge
  logic [2:0] smp_clk_ff;
  logic [TEMP_W-1:0] temp_meta_ff;
  logic [TEMP_W-1:0] temp_sync_ff;
  logic smp_edge;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_clk_ff <= 3'h0;
      temp_meta_ff <= '0;
      temp_sync_ff <= '0;
    end else if (i_ce) begin
      smp_clk_ff <= {smp_clk_ff[1:0], i_smp_clk};
      temp_meta_ff <= i_temp;
      temp_sync_ff <= temp_meta_ff;
    end
  end
  assign smp_edge = smp_clk_ff[1] & ~smp_clk_ff[2];

  // capture a reading; shutdown ignores conversions and keeps the last value
  logic signed [TEMP_W-1:0] temp_ff;
  logic temp_vld_ff;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= '0;
      temp_vld_ff <= 1'b0;
    end else if (i_ce && smp_edge && !shdn_ff) begin
      temp_vld_ff <= 1'b1;
      if (!CAP_NEG && temp_sync_ff[TEMP_W-1]) begin
        temp_ff <= '0;
      end else begin
        temp_ff <= temp_sync_ff;
      end
    end
  end
  assign o_smp_en = ~shdn_ff;

  ////////////////////////////////////////////////////////////////////////////
  // threshold flags with hysteresis on the deasserting side of upper and critical, the asserting side of lower
  // compare two bits wider so threshold minus hysteresis cannot wrap
  localparam int CW = TEMP_W + 2;
  logic signed [CW-1:0] t_w;
  logic signed [CW-1:0] up_w;
  logic signed [CW-1:0] lo_w;
  logic signed [CW-1:0] cr_w;
  logic signed [CW-1:0] hys_w;
  logic above_ff;
  logic below_ff;
  logic crit_ff_flag;
  logic nxt_above;
  logic nxt_below;
  logic nxt_crit;

  // hysteresis code to quarter-degree steps
  always_comb begin
    unique case (hys_ff)
      TSE_HYS_OFF: hys_w = '0;
      TSE_HYS_1P5: hys_w = CW'(TSE_HYS_STEPS_1P5);
      TSE_HYS_3P0: hys_w = CW'(TSE_HYS_STEPS_3P0);
      default: hys_w = CW'(TSE_HYS_STEPS_6P0);
    endcase
  end

  assign t_w = CW'(temp_ff);
  assign up_w = CW'(upper_ff);
  assign lo_w = CW'(lower_ff);
  assign cr_w = CW'(crit_ff);

  // above sets past upper, clears at upper less hysteresis; critical sets at its threshold, clears only past it less hysteresis;
  // below sets past lower less hysteresis, clears at lower
  always_comb begin
    nxt_above = above_ff;
    nxt_below = below_ff;
    nxt_crit = crit_ff_flag;
    if (t_w > up_w) begin
      nxt_above = 1'b1;
    end else if (t_w <= up_w - hys_w) begin
      nxt_above = 1'b0;
    end
    if (t_w < lo_w - hys_w) begin
      nxt_below = 1'b1;
    end else if (t_w >= lo_w) begin
      nxt_below = 1'b0;
    end
    if (t_w >= cr_w) begin
      nxt_crit = 1'b1;
    end else if (t_w < cr_w - hys_w) begin
      nxt_crit = 1'b0;
    end
  end

  // re-evaluated every cycle once a reading is valid and outside shutdown, so reprogrammed thresholds act at once
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      above_ff <= 1'b0;
      below_ff <= 1'b0;
      crit_ff_flag <= 1'b0;
    end else if (i_ce && temp_vld_ff && !shdn_ff) begin
      above_ff <= nxt_above;
      below_ff <= nxt_below;
      crit_ff_flag <= nxt_crit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event state
  logic alarm_win;
  logic alarm_prev_ff;
  logic alarm_cross;
  logic int_evt_ff;
  logic evt_cond;

  assign alarm_win = above_ff | below_ff;
  assign alarm_cross = alarm_win ^ alarm_prev_ff;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_prev_ff <= 1'b0;
    end else if (i_ce) begin
      alarm_prev_ff <= alarm_win;
    end
  end

  // interrupt latch: any window crossing in interrupt mode sets it, comparator mode holds it clear; a crossing beats a clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_evt_ff <= 1'b0;
    end else if (i_ce) begin
      if (alarm_cross && mode_ff) begin
        int_evt_ff <= 1'b1;
      end else if (clr_evt_wr || !mode_ff) begin
        int_evt_ff <= 1'b0;
      end
    end
  end

  // critical is always comparator-like, so clear-event never drops it
  always_comb begin
    if (shdn_ff || !CAP_TRIPS) begin
      evt_cond = 1'b0;
    end else if (crit_only_ff) begin
      evt_cond = crit_ff_flag;
    end else if (mode_ff) begin
      evt_cond = int_evt_ff | crit_ff_flag;
    end else begin
      evt_cond = alarm_win | crit_ff_flag;
    end
  end

  // registered pin drive; active-low is open-drain, active-high is push-pull
  logic status_ff;
  tse_pin_t pin_ff;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 1'b0;
      pin_ff <= '0;
    end else if (i_ce) begin
      status_ff <= evt_cond;
      if (pol_ff) begin
        pin_ff.oe <= 1'b1;
        pin_ff.o <= evt_cond & out_en_ff;
      end else begin
        pin_ff.oe <= evt_cond & out_en_ff;
        pin_ff.o <= 1'b0;
      end
    end
  end
  assign o_evt_pin = pin_ff;
  assign o_evt_status = status_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [15:0] cap_word;
  logic [15:0] cfg_word;
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;

  // capability word; upper bits stay zero
  always_comb begin
    cap_word = 16'h0000;
    cap_word[TSE_CAP_BASIC] = CAP_TRIPS;
    cap_word[TSE_CAP_ACCUR] = CAP_HI_ACC;
    cap_word[TSE_CAP_RANGE] = CAP_NEG;
    cap_word[TSE_CAP_RES_LO+1:TSE_CAP_RES_LO] = TSE_CAP_RES_CODE;
    cap_word[TSE_CAP_HV] = CAP_HV_PIN;
  end

  // configuration word; clear-event and 15:11 always read zero
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[TSE_CFG_MODE] = mode_ff;
    cfg_word[TSE_CFG_POL] = pol_ff;
    cfg_word[TSE_CFG_CRIT_ONLY] = crit_only_ff;
    cfg_word[TSE_CFG_OUT_EN] = out_en_ff;
    cfg_word[TSE_CFG_STATUS] = status_ff;
    cfg_word[TSE_CFG_CLR_EVT] = 1'b0;
    cfg_word[TSE_CFG_ALM_LOCK] = alm_lock_ff;
    cfg_word[TSE_CFG_CRIT_LOCK] = crit_lock_ff;
    cfg_word[TSE_CFG_SHDN] = shdn_ff;
    cfg_word[TSE_CFG_HYS_HI:TSE_CFG_HYS_LO] = hys_ff;
  end

  // address decode; unmapped indexes read zero; reads have no side effect
  always_comb begin
    unique case (i_bus.addr)
      TSE_ADDR_CAP: nxt_rdata = cap_word;
      TSE_ADDR_CFG: nxt_rdata = cfg_word;
      TSE_ADDR_UPPER: nxt_rdata = 16'(upper_ff);
      TSE_ADDR_LOWER: nxt_rdata = 16'(lower_ff);
      TSE_ADDR_CRIT: nxt_rdata = 16'(crit_ff);
      TSE_ADDR_TEMP: nxt_rdata = 16'(temp_ff);
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // data stands one cycle after the strobe and returns to zero otherwise
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (i_ce) begin
      rdata_ff <= i_bus.rd ? nxt_rdata : 16'h0000;
    end
  end
  assign o_rdata = rdata_ff;

endmodule // tse_event_cfg

// ==== testbench/tse_event_cfg_checker.sv ====
// assertion checker for the thermal sensor event and configuration block
`timescale 1ns/10ps
module tse_event_cfg_checker
  import tse_pkg::*;
#(
  parameter int TEMP_W = 11  // temperature width
) (
  input wire logic i_clk,               // block clock
  input wire logic i_rst_n,             // async reset, active low
  input wire logic i_ce,                // clock enable
  input wire tse_bus_req_t i_bus,       // register request
  input wire logic [15:0] o_rdata,      // read data
  input wire logic i_smp_clk,           // sample clock
  input wire logic [TEMP_W-1:0] i_temp, // temperature
  input wire logic o_smp_en,            // sampling allowed
  input wire tse_pin_t o_evt_pin,       // event pin
  input wire logic o_evt_status         // event condition
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////
  // cycles since the last sample edge or write; nothing else may move the event
  logic smp_q_ff;
  logic [4:0] cause_cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp_q_ff <= 1'b0;
      cause_cnt_ff <= 5'h1f;
    end else begin
      smp_q_ff <= i_smp_clk;
      if ((i_smp_clk && !smp_q_ff) || i_bus.wr) begin
        cause_cnt_ff <= 5'h00;
      end else if (cause_cnt_ff != 5'h1f) begin
        cause_cnt_ff <= cause_cnt_ff + 5'h01;
      end
    end
  end
  // polarity as the pin flop uses it: the pin follows a configuration write one cycle late
  logic pol_wr_ff;
  logic pol_pin_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pol_wr_ff <= TSE_CFG_RESET[TSE_CFG_POL];
      pol_pin_ff <= TSE_CFG_RESET[TSE_CFG_POL];
    end else if (i_ce) begin
      if (i_bus.wr && i_bus.addr == TSE_ADDR_CFG) begin
        pol_wr_ff <= i_bus.wdata[TSE_CFG_POL];
      end
      pol_pin_ff <= pol_wr_ff;
    end
  end
  ////////////////////////////////////////////////////////////
  // register reads
  AST_CAP_FIXED: assert property (
    (i_ce && i_bus.rd && i_bus.addr == TSE_ADDR_CAP)
    |=> (o_rdata[15:6] == 10'h000 && o_rdata[4:3] == TSE_CAP_RES_CODE))
    else $error("capability fixed bits wrong");
  AST_CFG_RSVD: assert property (
    (i_ce && i_bus.rd && i_bus.addr == TSE_ADDR_CFG)
    |=> (o_rdata[15:11] == 5'h00 && !o_rdata[TSE_CFG_CLR_EVT]))
    else $error("configuration reserved or clear bit not zero");
  AST_CFG_STATUS: assert property (
    (i_ce && i_bus.rd && i_bus.addr == TSE_ADDR_CFG)
    |=> (o_rdata[TSE_CFG_STATUS] == $past(o_evt_status) || o_rdata[TSE_CFG_STATUS] == o_evt_status))
    else $error("status bit disagrees with event condition");
  // pin against condition
  AST_PIN_LOW_ACTIVE: assert property (
    (!pol_pin_ff && o_evt_pin.oe) |-> (o_evt_status && !o_evt_pin.o))
    else $error("open-drain pin pulled low without event");
  AST_PIN_IDLE: assert property (
    (pol_pin_ff && !o_evt_status) |-> (o_evt_pin.oe && !o_evt_pin.o))
    else $error("push-pull pin not idle low without event");
  AST_PIN_HIGH_ACTIVE: assert property (
    o_evt_pin.o |-> (o_evt_pin.oe && o_evt_status))
    else $error("pin high without drive or event");
  // shutdown and event cause
  AST_SHDN_QUIET: assert property (
    !o_smp_en [*3] |-> !o_evt_status)
    else $error("event asserted in shutdown");
  AST_SHDN_CLEAR: assert property (
    (i_ce && i_bus.wr && i_bus.addr == TSE_ADDR_CFG && !i_bus.wdata[TSE_CFG_SHDN]) |=> o_smp_en)
    else $error("shutdown clear refused");
  AST_EVENT_CAUSE: assert property (
    $changed(o_evt_status) |-> cause_cnt_ff < 5'd12)
    else $error("event moved without sample or write");
endmodule // tse_event_cfg_checker

bind tse_event_cfg tse_event_cfg_checker #(.TEMP_W(TEMP_W)) i_tse_event_cfg_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_smp_clk(i_smp_clk), .i_temp(i_temp), .o_smp_en(o_smp_en), .o_evt_pin(o_evt_pin),
  .o_evt_status(o_evt_status));

// ==== testbench/tse_sense_model.sv ====
// behavioural thermal sensing unit: one reading, then one sample clock pulse
`timescale 1ns/10ps
module tse_sense_model #(
  parameter int TEMP_W = 11  // temperature width
) (
  input wire logic i_go,                 // toggles to request one conversion
  input wire logic [TEMP_W-1:0] i_val,   // reading to present
  output logic o_smp_clk,                // sample clock, still between conversions
  output logic [TEMP_W-1:0] o_temp       // reading, held until the next conversion
);
  // reading leads the edge by 207 ns, just over 4 clocks, and off the clock grid
  initial begin
    o_smp_clk = 1'b0;
    o_temp = '0;
  end
  always @(i_go) begin
    o_temp = i_val;
    #207 o_smp_clk = 1'b1;
    #200 o_smp_clk = 1'b0;
  end
endmodule // tse_sense_model

// ==== testbench/tse_event_cfg_tb.sv ====
// self-checking testbench for the thermal sensor event and configuration block
`timescale 1ns/10ps
module tse_event_cfg_tb;
  import tse_pkg::*;
  logic clk;
  logic rst_n;
  logic ce;
  tse_bus_req_t bus;
  logic [15:0] rdata;
  logic smp_clk;
  logic [10:0] temp;
  logic smp_en;
  tse_pin_t pin;
  logic status;
  logic sns_go;
  logic [10:0] sns_val;
  int fail_count;
  int compares;
  int cycles;
  ////////////////////////////////////////////////////////////
  // design and sensing unit; clock enable drops only in the first scenario
  tse_event_cfg i_tse_event_cfg (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_bus(bus),
    .o_rdata(rdata), .i_smp_clk(smp_clk), .i_temp(temp), .o_smp_en(smp_en),
    .o_evt_pin(pin), .o_evt_status(status));
  tse_sense_model i_tse_sense_model (.i_go(sns_go), .i_val(sns_val), .o_smp_clk(smp_clk),
    .o_temp(temp));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  // comparisons and bus cycles
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk16(n, e, rdata);
  endtask
  // one conversion, then enough cycles for synchronisers and the event pipeline
  task automatic smp(input logic [10:0] t);
    @(posedge clk);
    sns_val <= t;
    sns_go <= ~sns_go;
    repeat (20) @(posedge clk);
    #1;
  endtask
  // pin is {o, oe}: active low asserted drives 0, active high idles driven low
  task automatic evt(input string n, input logic s, input logic [1:0] p);
    repeat (3) @(posedge clk);
    #1;
    chk3(n, {s, p}, {status, pin});
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_cap;
    @(posedge clk);
    ce <= 1'b0;
    wr(TSE_ADDR_UPPER, 16'h0011);
    ce <= 1'b1;
    rd_chk("frozen by clock enable", TSE_ADDR_UPPER, 16'h0000);
    rd_chk("capability", TSE_ADDR_CAP, 16'h002f);
    rd_chk("config reset", TSE_ADDR_CFG, TSE_CFG_RESET);
    rd_chk("unmapped", 3'h6, 16'h0000);
    wr(TSE_ADDR_CFG, 16'hf830);
    rd_chk("config reserved", TSE_ADDR_CFG, 16'h0000);
  endtask
  task automatic t_comp;
    wr(TSE_ADDR_UPPER, 16'h0064);
    wr(TSE_ADDR_LOWER, 16'h0028);
    wr(TSE_ADDR_CRIT, 16'h00c8);
    wr(TSE_ADDR_CFG, 16'h0008);
    smp(11'h03c);
    evt("in window", 1'b0, 2'b00);
    smp(11'h078);
    evt("above window", 1'b1, 2'b01);
    rd_chk("status bit", TSE_ADDR_CFG, 16'h0018);
    wr(TSE_ADDR_CFG, 16'h0028);
    evt("clear in comparator", 1'b1, 2'b01);
    smp(11'h014);
    evt("below window", 1'b1, 2'b01);
    smp(11'h03c);
    evt("back in window", 1'b0, 2'b00);
  endtask
  task automatic t_hys;
    logic [10:0] steps;
    for (int c = 0; c < 4; c++) begin
      steps = (c == 0) ? 11'd0 : (11'd6 << (c - 1));
      wr(TSE_ADDR_CFG, {5'h00, c[1:0], 9'h008});
      rd_chk("hysteresis field", TSE_ADDR_CFG, {5'h00, c[1:0], 9'h008});
      smp(11'h078);
      evt("hys set", 1'b1, 2'b01);
      smp(11'd101 - steps);
      evt("hys hold", 1'b1, 2'b01);
      smp(11'd100 - steps);
      evt("hys clear", 1'b0, 2'b00);
    end
  endtask
  task automatic t_pol;
    wr(TSE_ADDR_CFG, 16'h000a);
    smp(11'h078);
    evt("active high", 1'b1, 2'b11);
    wr(TSE_ADDR_CFG, 16'h0002);
    evt("output disabled", 1'b1, 2'b01);
    rd_chk("status while disabled", TSE_ADDR_CFG, 16'h0012);
    smp(11'h03c);
    wr(TSE_ADDR_CFG, 16'h0009);
    evt("interrupt idle", 1'b0, 2'b00);
  endtask
  task automatic t_int;
    smp(11'h078);
    evt("window exit", 1'b1, 2'b01);
    wr(TSE_ADDR_CFG, 16'h0029);
    evt("cleared", 1'b0, 2'b00);
    smp(11'h07d);
    evt("no new crossing", 1'b0, 2'b00);
    smp(11'h03c);
    evt("window entry", 1'b1, 2'b01);
    wr(TSE_ADDR_CFG, 16'h0029);
    smp(11'h0d2);
    wr(TSE_ADDR_CFG, 16'h0029);
    evt("critical not cleared", 1'b1, 2'b01);
    smp(11'h03c);
    wr(TSE_ADDR_CFG, 16'h0029);
    evt("critical gone", 1'b0, 2'b00);
  endtask
  task automatic t_crit_only;
    wr(TSE_ADDR_CFG, 16'h000c);
    smp(11'h078);
    evt("alarm masked", 1'b0, 2'b00);
    smp(11'h0d2);
    evt("critical only", 1'b1, 2'b01);
    smp(11'h03c);
    wr(TSE_ADDR_CFG, 16'h0008);
  endtask
  task automatic t_shdn;
    smp(11'h078);
    wr(TSE_ADDR_CFG, 16'h0108);
    evt("shutdown quiet", 1'b0, 2'b00);
    chk3("sampling off", 3'h0, {2'h0, smp_en});
    wr(TSE_ADDR_UPPER, 16'h0070);
    rd_chk("upper in shutdown", TSE_ADDR_UPPER, 16'h0070);
    rd_chk("config in shutdown", TSE_ADDR_CFG, 16'h0108);
    wr(TSE_ADDR_CFG, 16'h0008);
    evt("after shutdown", 1'b1, 2'b01);
    chk3("sampling on", 3'h1, {2'h0, smp_en});
    smp(11'h03c);
    smp(11'h078);
    evt("sampling resumed", 1'b1, 2'b01);
    wr(TSE_ADDR_UPPER, 16'h0064);
    smp(11'h03c);
  endtask
  // locks are sticky, so this runs last and ends with a reset and checks that the locks are gone
  task automatic t_lock;
    wr(TSE_ADDR_CFG, 16'h00c8);
    rd_chk("locks set", TSE_ADDR_CFG, 16'h00c8);
    wr(TSE_ADDR_UPPER, 16'h0050);
    wr(TSE_ADDR_LOWER, 16'h0010);
    wr(TSE_ADDR_CRIT, 16'h0096);
    rd_chk("upper locked", TSE_ADDR_UPPER, 16'h0064);
    rd_chk("lower locked", TSE_ADDR_LOWER, 16'h0028);
    rd_chk("critical locked", TSE_ADDR_CRIT, 16'h00c8);
    wr(TSE_ADDR_CFG, 16'h0705);
    rd_chk("config frozen", TSE_ADDR_CFG, 16'h00c8);
    chk3("shutdown refused", 3'h1, {2'h0, smp_en});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("power cycle", TSE_ADDR_CFG, 16'h0000);
    wr(TSE_ADDR_UPPER, 16'h0050);
    rd_chk("upper unlocked", TSE_ADDR_UPPER, 16'h0050);
  endtask
  ////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    sns_go = 1'b0;
    sns_val = 11'h000;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_cap();
    t_comp();
    t_hys();
    t_pol();
    t_int();
    t_crit_only();
    t_shdn();
    t_lock();
    results();
  end
endmodule // tse_event_cfg_tb
